// ---- ccd_frontend_output_control_bench.sv ----
// Self-checking bench for the CCD front end output control block.
`timescale 1ns/1ps
module ccd_frontend_output_control_bench;
	logic        sys_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        ob = 1'b0, pb = 1'b0, oe_dis = 1'b0, sleep = 1'b0, tst = 1'b0;
	logic        lin = 1'b0, tin = 1'b0, ofs_en = 1'b0, ao_start = 1'b0;
	logic [3:0]  ofs_v = 4'h0;
	logic [10:0] gain = 11'h000;
	logic [4:0]  clamp = 5'h00;
	logic        conv, bs, ss, ao_done, gbad;
	logic [9:0]  lvl, po, po_oe_n, clamp_lvl;
	logic [31:0] seed = 32'hDA7F81A8;
	logic [9:0]  expq[$];
	int          err_total = 0;
	int          check_count = 0;
	always #10 sys_clk = ~sys_clk;
	cfo_timing_gen u_gen (.sys_clk(sys_clk), .conversion_clock(conv),
		.black_sample_strobe(bs), .signal_sample_strobe(ss), .pixel_level(lvl));
	cfo_frontend u_dut (.sys_clk(sys_clk), .rstn(rstn), .conversion_clock(conv),
		.black_sample_strobe(bs), .signal_sample_strobe(ss), .optical_black_pulse(ob),
		.preblank_in(pb), .out_disable_in(oe_dis), .pixel_level(lvl),
		.low_power_sleep(sleep), .test_mode(tst), .lower_bits_invert(lin),
		.top_bit_invert(tin), .ccd_offset_cancel_en(ofs_en), .ccd_offset_value(ofs_v),
		.gain_code(gain), .clamp_set(clamp), .auto_offset_start(ao_start),
		.pixel_out(po), .pixel_out_oe_n(po_oe_n), .clamp_level(clamp_lvl),
		.auto_offset_done(ao_done), .gain_code_bad(gbad));
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [9:0] level(input int b, input int s, input int g,
		input int n, input logic obx, input logic en, input logic [3:0] o);
		int d;
		d = s - b;
		if (obx && en)
			d = d - int'($signed(o));
		if (d < 0)
			d = 0;
		if (g >= 0)
			d = d * (1024 + g) / 1024;
		else
			d = d * (256 + g) / 256;
		d = d + 32 + ((n > 24) ? 24 : n);
		return (d > 1023) ? 10'h3FF : d[9:0];
	endfunction
	task automatic chk(input string what, input logic [10:0] e, input logic [10:0] got);
		check_count++;
		if (got !== e)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, e, got);
		end
	endtask
	task automatic conclude();
		if (err_total == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Only the inversions outrank preblank once output enable, sleep and test are low.
	task automatic pix(input int j);
		logic [31:0] r;
		logic [9:0]  m;
		int          b;
		int          s;
		int          g;
		r = rnd();
		b = r[7:0];
		s = b + r[16:8];
		g = r[17] ? int'(r[27:18]) : -int'(r[27:21] % 81) - 1;
		if (j < 3)
			g = (j == 0) ? 1023 : ((j == 1) ? -81 : 0);
		@(negedge sys_clk);
		gain = g[10:0];
		clamp = r[4:0];
		ob = r[28];
		ofs_en = r[29];
		ofs_v = r[31:28];
		pb = r[30];
		u_gen.run(b[9:0], s[9:0]);
		expq.push_back(level(b, s, g, r[4:0], r[28], r[29], r[31:28]));
		m = {tin, {9{lin}}};
		chk("oe_n", 11'h000, po_oe_n);
		if (expq.size() == 5)
		begin
			if (pb && !lin && !tin)
				chk("blank", 11'h020, po);
			else
				chk("pixel", expq[0] ^ m, po);
			void'(expq.pop_front());
		end
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	logic [10:0] codes[6] = '{11'h000, 11'h3FF, 11'h400, 11'h7AF, 11'h7AE, 11'h7FF};
	logic        bads[6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
	int          w;
	initial
	begin
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		chk("rst oe_n", 11'h3FF, po_oe_n);
		chk("rst clamp", 11'h020, clamp_lvl);
		chk("rst done", 11'h000, ao_done);
		rstn = 1'b1;
		for (int n = 0; n < 32; n++)
		begin
			@(negedge sys_clk);
			clamp = n[4:0];
			repeat (2) @(negedge sys_clk);
			chk("clamp", 11'h020 + 11'((n > 24) ? 24 : n), clamp_lvl);
		end
		@(negedge sys_clk);
		ao_start = 1'b1;
		repeat (4) @(negedge sys_clk);
		ao_start = 1'b0;
		pix(5);
		w = 0;
		while (ao_done !== 1'b1 && w < 50)
		begin
			@(negedge sys_clk);
			w++;
		end
		chk("ao done", 11'h001, ao_done);
		for (int k = 0; k < 4; k++)
		begin
			@(negedge sys_clk);
			{lin, tin} = k[1:0];
			for (int j = 0; j < 8; j++)
				pix(j);
		end
		for (int i = 0; i < 6; i++)
		begin
			@(negedge sys_clk);
			gain = codes[i];
			repeat (3) @(negedge sys_clk);
			chk("gain bad", bads[i], gbad);
		end
		for (int i = 0; i < 64; i++)
		begin
			@(negedge sys_clk);
			{oe_dis, sleep, tst, lin, tin, pb} = i[5:0];
			repeat (4) @(negedge sys_clk);
			if (oe_dis)
				chk("hiz", 11'h3FF, po_oe_n);
			else if (sleep)
				chk("sleep", 11'h3FF, po_oe_n);
			else if (tst)
				chk("test", 11'h155 ^ {tin, {9{lin}}}, po);
			else if (pb && !lin && !tin)
				chk("blank", 11'h020, po);
			else
				chk("drive", 11'h000, po_oe_n);
		end
		conclude();
	end
endmodule // ccd_frontend_output_control_bench

// ---- cfo_cds.sv ----
// Correlated double sampler with CCD offset cancel on synchronised strobes.
`timescale 1ns/1ps
`include "cfo_consts.svh"
module cfo_cds #(
	parameter int DW = `CFO_DATA_W
) (
	input  wire logic                  sys_clk,
	input  wire logic                  rstn,
	input  wire logic                  blk_rise,
	input  wire logic                  sig_rise,
	input  wire logic [DW-1:0]         pixel_level,
	input  wire logic                  ob_active,
	input  wire logic                  ofs_en,
	input  wire logic [`CFO_OFS_W-1:0] ofs_val,
	output logic      [DW-1:0]         diff_out,
	output logic                       diff_valid
);
	logic [DW-1:0] black_reg;
	logic [DW:0]   raw;
	logic [DW:0]   corr;

	// Black level is caught on the first strobe's rise.
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			black_reg <= '0;
		else if (blk_rise)
			black_reg <= pixel_level;
	end

	// Offset is signal minus black, positive when signal is larger.
	always_comb
	begin
		raw  = {1'b0, pixel_level} - {1'b0, black_reg};
		corr = raw;
		if (ofs_en && ob_active)
			corr = raw - {{(DW+1-`CFO_OFS_W){ofs_val[`CFO_OFS_W-1]}}, ofs_val};
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			diff_out   <= '0;
			diff_valid <= 1'b0;
		end
		else
		begin
			diff_valid <= sig_rise;
			if (sig_rise)
				diff_out <= corr[DW] ? '0 : corr[DW-1:0];
		end
	end
endmodule // cfo_cds

// ---- cfo_consts.svh ----
// Constants for the CCD front end output control block.
`ifndef CFO_CONSTS_SVH
`define CFO_CONSTS_SVH
`define CFO_DATA_W        10
`define CFO_GAIN_W        11
`define CFO_CLAMP_W       5
`define CFO_OFS_W         4
`define CFO_PIPE_DEPTH    5
`define CFO_CLAMP_BASE    10'h020
`define CFO_CLAMP_MAXSET  5'h18
`define CFO_PREBLANK_CODE 10'h020
`define CFO_GAIN_POS_MAX  11'h3FF
`define CFO_GAIN_NEG_MIN  11'h7AF
`define CFO_TEST_PATTERN  10'h155
`define CFO_OUT_RESET     10'h000
`endif

// ---- cfo_frontend.sv ----
// Top of the CCD front end output control: pins, sampling, pipeline, output modes.
//
// Operation
// - Black level on black strobe rise, pixel level on signal strobe rise.
// - Five-bit clamp setting n gives clamp level 32+n LSB, up to 56.
// - Eleven-bit gain code spans roughly -3.3 dB to 34.7 dB; the linear model reaches only about 6 dB at code 1023.
// - Codes 0 to 1023 add 0.034 dB per step from unity gain; the model adds 1/1024 of unity per step instead.
// - Codes -1 to -81, two's complement, lower gain multiple 0.0039 per step.
// - Controller starts auto offset cancel at power-up; device clears internal offsets.
// - Output enable input high floats all ten outputs; low drives them.
// - Pre-blanking input high forces output code 32 LSB.
// - Output enable, standby, test and inversions all override pre-blanking.
// - Offset cancel enable applies the four-bit correction value; else none.
// - Correction acts during optical black pulse; offset is signal minus black.
// - Output word changes on the conversion clock rising edge; forced modes change it on the next system clock instead.
// - A sample's result appears five conversion clocks after sampling.
// - Standby with output enable low floats outputs in low power.
// - Top inversion flips bit 9, lower inversion bits 8..0, both all.
// - Pre-blanking only when its input high and every other control low.
`timescale 1ns/1ps
`include "cfo_consts.svh"
module cfo_frontend #(
	parameter int DW    = `CFO_DATA_W,
	parameter int DEPTH = `CFO_PIPE_DEPTH
) (
	input  wire logic                    sys_clk,
	input  wire logic                    rstn,
	input  wire logic                    conversion_clock,
	input  wire logic                    black_sample_strobe,
	input  wire logic                    signal_sample_strobe,
	input  wire logic                    optical_black_pulse,
	input  wire logic                    preblank_in,
	input  wire logic                    out_disable_in,
	input  wire logic [DW-1:0]           pixel_level,
	input  wire logic                    low_power_sleep,
	input  wire logic                    test_mode,
	input  wire logic                    lower_bits_invert,
	input  wire logic                    top_bit_invert,
	input  wire logic                    ccd_offset_cancel_en,
	input  wire logic [`CFO_OFS_W-1:0]   ccd_offset_value,
	input  wire logic [`CFO_GAIN_W-1:0]  gain_code,
	input  wire logic [`CFO_CLAMP_W-1:0] clamp_set,
	input  wire logic                    auto_offset_start,
	output logic      [DW-1:0]           pixel_out,
	output logic      [DW-1:0]           pixel_out_oe_n,
	output logic      [DW-1:0]           clamp_level,
	output logic                         auto_offset_done,
	output logic                         gain_code_bad
);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	localparam int NS = 6;
	logic [NS-1:0] s1_reg;
	logic [NS-1:0] s2_reg;
	logic [NS-1:0] s3_reg;
	logic [NS-1:0] pins;
	assign pins = {conversion_clock, black_sample_strobe, signal_sample_strobe,
		optical_black_pulse, preblank_in, out_disable_in};

	// Third stage only feeds edge detection; the levels are read from the second stage.
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end
		else
		begin
			s1_reg <= pins;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	logic conv_rise;
	logic blk_rise;
	logic sig_rise;
	logic ob_s;
	logic preblank_in_s;
	logic oe_hi_s;
	assign conv_rise = s2_reg[5] & ~s3_reg[5];
	assign blk_rise  = s2_reg[4] & ~s3_reg[4];
	assign sig_rise  = s2_reg[3] & ~s3_reg[3];
	assign ob_s      = s2_reg[2];
	assign preblank_in_s    = s2_reg[1];
	assign oe_hi_s   = s2_reg[0];

	// ------------------------------------------------------------
	// Power-up offset cancel
	// ------------------------------------------------------------
	// The analog trim itself is outside; this tracks the request and its completion.
	logic ao_busy_reg;
	logic ao_done_reg;
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ao_busy_reg <= 1'b0;
			ao_done_reg <= 1'b0;
		end
		else if (auto_offset_start && !ao_busy_reg)
		begin
			ao_busy_reg <= 1'b1;
			ao_done_reg <= 1'b0;
		end
		else if (ao_busy_reg && conv_rise)
		begin
			ao_busy_reg <= 1'b0;
			ao_done_reg <= 1'b1;
		end
	end
	assign auto_offset_done = ao_done_reg;

	// ------------------------------------------------------------
	// Sampling and gain
	// ------------------------------------------------------------
	logic [DW-1:0] diff;
	logic          diff_v;
	logic [DW-1:0] level;
	logic          level_v;

	cfo_cds #(.DW(DW)) u_cds (
		.sys_clk    (sys_clk),
		.rstn       (rstn),
		.blk_rise   (blk_rise),
		.sig_rise   (sig_rise),
		.pixel_level(pixel_level),
		.ob_active  (ob_s),
		.ofs_en     (ccd_offset_cancel_en),
		.ofs_val    (ccd_offset_value),
		.diff_out   (diff),
		.diff_valid (diff_v)
	);

	cfo_gain #(.DW(DW)) u_gain (
		.sys_clk      (sys_clk),
		.rstn         (rstn),
		.diff_in      (diff),
		.diff_valid   (diff_v),
		.gain_code    (gain_code),
		.clamp_set    (clamp_set),
		.level_out    (level),
		.level_valid  (level_v),
		.gain_code_bad(gain_code_bad)
	);

	logic [DW-1:0] clamp_reg;
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			clamp_reg <= `CFO_CLAMP_BASE;
		else if (clamp_set > `CFO_CLAMP_MAXSET)
			clamp_reg <= `CFO_CLAMP_BASE + 10'(`CFO_CLAMP_MAXSET);
		else
			clamp_reg <= `CFO_CLAMP_BASE + 10'(clamp_set);
	end
	assign clamp_level = clamp_reg;

	// ------------------------------------------------------------
	// Conversion pipeline
	// ------------------------------------------------------------
	// Newest result waits here; each conversion clock rise shifts the chain.
	logic [DW-1:0] hold_reg;
	logic [DW-1:0] pipe_reg [DEPTH-1];
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			hold_reg <= '0;
		else if (level_v)
			hold_reg <= level;
	end

	genvar gi;
	generate
		for (gi = 0; gi < DEPTH - 1; gi++)
		begin : g_pipe
			// The first stage is split off so that no stage ever indexes below zero.
			if (gi == 0)
			begin : g_first
				always_ff @(posedge sys_clk or negedge rstn)
				begin
					if (!rstn)
						pipe_reg[gi] <= '0;
					else if (conv_rise)
						pipe_reg[gi] <= hold_reg;
				end
			end
			else
			begin : g_next
				always_ff @(posedge sys_clk or negedge rstn)
				begin
					if (!rstn)
						pipe_reg[gi] <= '0;
					else if (conv_rise)
						pipe_reg[gi] <= pipe_reg[gi - 1];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Output modes
	// ------------------------------------------------------------
	function automatic cfo_pkg::cfo_mode_t pick_mode(input logic oe_hi, input logic sl,
		input logic tst, input logic lin, input logic tin, input logic pb);
		if (oe_hi)
			return cfo_pkg::CFO_HIZ;
		if (sl)
			return cfo_pkg::CFO_SLEEP;
		if (tst)
			return cfo_pkg::CFO_TEST;
		if (pb && !lin && !tin)
			return cfo_pkg::CFO_PREBLANK;
		return cfo_pkg::CFO_NORMAL;
	endfunction

	function automatic logic [DW-1:0] inv_word(input logic [DW-1:0] w, input logic lin,
		input logic tin);
		return w ^ {tin, {(DW-1){lin}}};
	endfunction

	cfo_pkg::cfo_mode_t mode;
	assign mode = pick_mode(oe_hi_s, low_power_sleep, test_mode, lower_bits_invert,
		top_bit_invert, preblank_in_s);

	logic [DW-1:0] pout_reg;
	logic [DW-1:0] oen_reg;
	// Forced modes land on the output register at once, ignoring pipe contents.
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pout_reg <= `CFO_OUT_RESET;
			oen_reg  <= '1;
		end
		else
		begin
			case (mode)
				cfo_pkg::CFO_HIZ, cfo_pkg::CFO_SLEEP:
				begin
					oen_reg  <= '1;
					pout_reg <= `CFO_OUT_RESET;
				end
				cfo_pkg::CFO_TEST:
				begin
					oen_reg  <= '0;
					pout_reg <= inv_word(`CFO_TEST_PATTERN, lower_bits_invert, top_bit_invert);
				end
				cfo_pkg::CFO_PREBLANK:
				begin
					oen_reg  <= '0;
					pout_reg <= `CFO_PREBLANK_CODE;
				end
				cfo_pkg::CFO_NORMAL:
				begin
					oen_reg <= '0;
					if (conv_rise)
						pout_reg <= inv_word(pipe_reg[DEPTH-2], lower_bits_invert,
							top_bit_invert);
				end
				default:
				begin
					oen_reg  <= '1;
					pout_reg <= `CFO_OUT_RESET;
				end
			endcase
		end
	end
	assign pixel_out      = pout_reg;
	assign pixel_out_oe_n = oen_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_blank_req;
		!oe_hi_s && !low_power_sleep && !test_mode && !lower_bits_invert
			&& !top_bit_invert && preblank_in_s;
	endsequence

	a_hiz_when_disabled: assert property (@(posedge sys_clk) disable iff (!rstn)
		oe_hi_s |=> (pixel_out_oe_n == '1))
		else $error("Outputs driven while output enable input high.");
	a_sleep_hiz: assert property (@(posedge sys_clk) disable iff (!rstn)
		(!oe_hi_s && low_power_sleep) |=> (pixel_out_oe_n == '1))
		else $error("Outputs driven in standby.");
	a_preblank_code: assert property (@(posedge sys_clk) disable iff (!rstn)
		s_blank_req |=> (pixel_out == `CFO_PREBLANK_CODE) && (pixel_out_oe_n == '0))
		else $error("Pre-blanking code missing.");
	a_blank_priority: assert property (@(posedge sys_clk) disable iff (!rstn)
		(preblank_in_s && !oe_hi_s && !low_power_sleep && test_mode)
		|=> (pixel_out_oe_n == '0) && (pixel_out == (`CFO_TEST_PATTERN
			^ {$past(top_bit_invert), {(DW-1){$past(lower_bits_invert)}}})))
		else $error("Pre-blanking overrode test mode.");
	a_out_on_edge: assert property (@(posedge sys_clk) disable iff (!rstn)
		(mode == cfo_pkg::CFO_NORMAL && $past(mode) == cfo_pkg::CFO_NORMAL && !conv_rise)
		|=> $stable(pixel_out))
		else $error("Output changed without a conversion clock rise.");
	a_invert_top: assert property (@(posedge sys_clk) disable iff (!rstn)
		(mode == cfo_pkg::CFO_NORMAL && conv_rise)
		|=> pixel_out[DW-1] == ($past(pipe_reg[DEPTH-2][DW-1]) ^ $past(top_bit_invert)))
		else $error("Top bit inversion wrong.");
	a_invert_low: assert property (@(posedge sys_clk) disable iff (!rstn)
		(mode == cfo_pkg::CFO_NORMAL && conv_rise)
		|=> pixel_out[DW-2:0] == ($past(pipe_reg[DEPTH-2][DW-2:0])
			^ {(DW-1){$past(lower_bits_invert)}}))
		else $error("Lower bit inversion wrong.");
	a_clamp_range: assert property (@(posedge sys_clk) disable iff (!rstn)
		(clamp_set <= `CFO_CLAMP_MAXSET) |=> (clamp_level == `CFO_CLAMP_BASE
			+ 10'($past(clamp_set))))
		else $error("Clamp level does not track setting.");
	a_offset_done: assert property (@(posedge sys_clk) disable iff (!rstn)
		(ao_busy_reg && conv_rise) |=> auto_offset_done)
		else $error("Offset cancel did not complete.");
endmodule // cfo_frontend

// ---- cfo_gain.sv ----
// Gain stage: clamp offset plus gain code scaling of the sampled difference.
`timescale 1ns/1ps
`include "cfo_consts.svh"
module cfo_gain #(
	parameter int DW = `CFO_DATA_W
) (
	input  wire logic                    sys_clk,
	input  wire logic                    rstn,
	input  wire logic [DW-1:0]           diff_in,
	input  wire logic                    diff_valid,
	input  wire logic [`CFO_GAIN_W-1:0]  gain_code,
	input  wire logic [`CFO_CLAMP_W-1:0] clamp_set,
	output logic      [DW-1:0]           level_out,
	output logic                         level_valid,
	output logic                         gain_code_bad
);
	// Linear-in-code scaling; the true dB law is analog and is only approximated.
	logic signed [`CFO_GAIN_W-1:0] g;
	logic [DW+11:0]                prod;
	logic [DW+2:0]                 sum;
	logic [`CFO_CLAMP_W-1:0]       cs;

	always_comb
	begin
		g = gain_code;
		// Clamp setting above 24 is held at 24.
		cs = (clamp_set > `CFO_CLAMP_MAXSET) ? `CFO_CLAMP_MAXSET : clamp_set;
		if (g >= 0)
			prod = ({12'h000, diff_in} * (22'(g) + 22'h000400)) >> 10;
		else
			prod = ({12'h000, diff_in} * (22'h000100 + 22'(signed'(g)))) >> 8;
		sum = 13'(prod) + {3'h0, `CFO_CLAMP_BASE} + 13'(cs);
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			level_out     <= '0;
			level_valid   <= 1'b0;
			gain_code_bad <= 1'b0;
		end
		else
		begin
			level_valid   <= diff_valid;
			gain_code_bad <= (g > $signed(`CFO_GAIN_POS_MAX)) || (g < $signed(`CFO_GAIN_NEG_MIN));
			if (diff_valid)
				level_out <= (sum > 13'h03FF) ? 10'h3FF : sum[DW-1:0];
		end
	end
endmodule // cfo_gain

// ---- cfo_pkg.sv ----
// Types for the CCD front end output control block.
package cfo_pkg;
	typedef enum logic [2:0] {
		CFO_HIZ,
		CFO_SLEEP,
		CFO_TEST,
		CFO_PREBLANK,
		CFO_NORMAL
	} cfo_mode_t;
endpackage

// ---- cfo_timing_gen.sv ----
// Timing generator model: sample strobes, sample level and conversion clock.
`timescale 1ns/1ps
`include "cfo_consts.svh"
module cfo_timing_gen (
	input  wire logic                  sys_clk,
	output logic                       conversion_clock,
	output logic                       black_sample_strobe,
	output logic                       signal_sample_strobe,
	output logic [`CFO_DATA_W-1:0]     pixel_level
);
	initial
	begin
		conversion_clock = 1'b0;
		black_sample_strobe = 1'b0;
		signal_sample_strobe = 1'b0;
		pixel_level = 10'h3FF;
	end
	// The level is inverted once its strobe drops, so a late sample shows up as a mismatch.
	task automatic hold(input logic [9:0] v, input logic blk);
		@(negedge sys_clk);
		pixel_level = v;
		black_sample_strobe = blk;
		signal_sample_strobe = ~blk;
		repeat (5) @(negedge sys_clk);
		black_sample_strobe = 1'b0;
		signal_sample_strobe = 1'b0;
		pixel_level = ~v;
		repeat (2) @(negedge sys_clk);
	endtask
	task automatic run(input logic [9:0] blk, input logic [9:0] sig);
		hold(blk, 1'b1);
		hold(sig, 1'b0);
		repeat (4) @(negedge sys_clk);
		conversion_clock = 1'b1;
		repeat (4) @(negedge sys_clk);
		conversion_clock = 1'b0;
		repeat (4) @(negedge sys_clk);
	endtask
endmodule // cfo_timing_gen
